// ===== cpu_status_flags_unit.v
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - eight flag bits; top four feed jumps
// - plain loads write the flags directly
// - flag update colliding with direct write unpredictable
// - carry from carry-out or borrow at bit 7
// - shift carry takes last bit shifted out
// - carry can be set, cleared, inverted
// - zero set when arithmetic/logic result zero
// - zero set when bit-test/shift result zero
// - sign copies result most significant bit
// - overflow on signed range exceeded
// - logic operations clear overflow
// - decimal bit records add versus subtract
// - half carry from bit 3 or 4 borrow
// - decimal adjust uses half carry and mode
// - fast irq bit set on entry, cleared on return
// - fast irq bit blocks interrupts, selects fast return
// - bank bit cleared or set by bank instructions
// - branch target adds signed byte to next address
// - register pair addresses must be even
`include "status_flags_map.vh"

module cpu_status_flags_unit (
  // clock, reset, enable
  input  wire        clk,
  input  wire        resetn,
  input  wire        clk_en,
  // cpu execution port
  input  wire        exec_valid,
  input  wire [3:0]  exec_op,
  input  wire [7:0]  exec_a,
  input  wire [7:0]  exec_b,
  input  wire        exec_cin,
  input  wire        exec_shift_out,
  input  wire        load_we,
  input  wire [7:0]  load_data,
  input  wire [15:0] next_pc,
  input  wire [7:0]  branch_disp,
  input  wire [7:0]  pair_addr,
  // flag outputs for the cpu
  output reg  [7:0]  flags_q,
  output reg  [3:0]  jump_flags_q,
  output reg         irq_block_q,
  output reg         fast_return_q,
  output reg         bank_sel_q,
  output reg  [7:0]  result_q,
  output reg  [15:0] branch_target_q,
  output reg         pair_err_q,
  // classic wishbone slave
  input  wire [9:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  // ----------------------------------------------------------
  // functions
  // ----------------------------------------------------------
  // zero detect is shared by every result path
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  // signed overflow of a+b (or a-b with b already inverted)
  function sum_ovf;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      sum_ovf = (a[7] == b[7]) && (r[7] != a[7]);
    end
  endfunction

  // nine-bit sum, bit 8 is the carry out of bit 7
  function [8:0] add9;
    input [7:0] x;
    input [7:0] y;
    input       c;
    begin
      add9 = {1'b0, x} + {1'b0, y} + {8'h00, c};
    end
  endfunction

  // nine-bit difference, bit 8 is the borrow out of bit 7
  function [8:0] sub9;
    input [7:0] x;
    input [7:0] y;
    input       c;
    begin
      sub9 = {1'b0, x} - {1'b0, y} - {8'h00, c};
    end
  endfunction

  // low nibble sum, bit 4 is the carry out of bit 3
  function [4:0] nib_add;
    input [3:0] x;
    input [3:0] y;
    input       c;
    begin
      nib_add = {1'b0, x} + {1'b0, y} + {4'h0, c};
    end
  endfunction

  // low nibble difference, bit 4 is the borrow out of the nibble
  function [4:0] nib_sub;
    input [3:0] x;
    input [3:0] y;
    input       c;
    begin
      nib_sub = {1'b0, x} - {1'b0, y} - {4'h0, c};
    end
  endfunction

  // ----------------------------------------------------------
  // operation source mux
  // ----------------------------------------------------------
  reg  [31:0] ctrl_q;
  reg  [31:0] ctrl_d;
  reg         sw_go_q;
  wire        go;
  wire [3:0]  op;
  wire [7:0]  a;
  wire [7:0]  b;
  wire        cin;

  // software injection wins over the cpu port for that one cycle
  assign go  = exec_valid | sw_go_q;
  assign op  = sw_go_q ? ctrl_q[`CTRL_OP_LSB+3:`CTRL_OP_LSB] : exec_op;
  assign a   = sw_go_q ? ctrl_q[`CTRL_A_LSB+7:`CTRL_A_LSB] : exec_a;
  assign b   = sw_go_q ? ctrl_q[`CTRL_B_LSB+7:`CTRL_B_LSB] : exec_b;
  assign cin = sw_go_q ? ctrl_q[`CTRL_CIN_BIT] : exec_cin;

  // ----------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------
  reg  [8:0]  sum9;
  reg  [4:0]  nib5;
  reg  [7:0]  res;
  reg  [7:0]  adj;
  reg  [7:0]  flags_d;
  reg         collide;

  // operand conventions of the execution port:
  // logic and shift results are computed by the cpu and arrive in a,
  // so this block only judges them; the shift carry arrives on its
  // own pin because the operand alone cannot tell the direction.
  // inc/dec passes its step in b (01 or FF) and leaves carry alone.
  // decimal adjust reads carry, half carry and the decimal bit left
  // by the previous add or subtract, so nothing may run in between.
  // without go nothing changes: every flag keeps its old value
  always @* begin
    flags_d = flags_q;
    res     = result_q;
    sum9    = 9'h000;
    nib5    = 5'h00;
    adj     = 8'h00;
    if (go) begin
      case (op)
        `OP_ADD: begin
          sum9 = add9(a, b, cin);
          nib5 = nib_add(a[3:0], b[3:0], cin);
          res  = sum9[7:0];
          flags_d[`FLAG_CARRY] = sum9[8];
          flags_d[`FLAG_OVERFLOW] = sum_ovf(a, b, res);
          flags_d[`FLAG_DEC_ADJ] = 1'b0;
          flags_d[`FLAG_HALF_CARRY] = nib5[4];
        end
        `OP_SUB: begin
          sum9 = sub9(a, b, cin);
          nib5 = nib_sub(a[3:0], b[3:0], cin);
          res  = sum9[7:0];
          flags_d[`FLAG_CARRY] = sum9[8];
          flags_d[`FLAG_OVERFLOW] = sum_ovf(a, ~b, res);
          flags_d[`FLAG_DEC_ADJ] = 1'b1;
          // borrow out of bit 3 is the low nibble's borrow
          flags_d[`FLAG_HALF_CARRY] = nib5[4];
        end
        `OP_INC_DEC: begin
          // b carries the signed step (01 or FF); carry untouched
          res = a + b;
          flags_d[`FLAG_OVERFLOW] = sum_ovf(a, b, res);
        end
        `OP_LOGIC: begin
          res = a; // logic result computed by the cpu
          flags_d[`FLAG_OVERFLOW] = 1'b0;
        end
        `OP_SHIFT: begin
          res = a;
          flags_d[`FLAG_CARRY] = exec_shift_out;
        end
        `OP_BIT_TEST: begin
          res = a & b;
        end
        `OP_DEC_ADJ: begin
          // correction picked from carry, half carry and mode
          if (flags_q[`FLAG_HALF_CARRY] || (a[3:0] > 4'h9)) begin
            adj[3:0] = 4'h6;
          end
          if (flags_q[`FLAG_CARRY] || (a > 8'h99)) begin
            adj[7:4] = 4'h6;
            flags_d[`FLAG_CARRY] = 1'b1;
          end
          res = flags_q[`FLAG_DEC_ADJ] ? a - adj : a + adj;
        end
        `OP_SET_CARRY: flags_d[`FLAG_CARRY] = 1'b1;
        `OP_CLR_CARRY: flags_d[`FLAG_CARRY] = 1'b0;
        `OP_CPL_CARRY: flags_d[`FLAG_CARRY] = ~flags_q[`FLAG_CARRY];
        `OP_FAST_IRQ_ENTER: flags_d[`FLAG_FAST_IRQ] = 1'b1;
        `OP_IRQ_RETURN: flags_d[`FLAG_FAST_IRQ] = 1'b0;
        `OP_BANK_ZERO: flags_d[`FLAG_BANK] = 1'b0;
        `OP_BANK_ONE: flags_d[`FLAG_BANK] = 1'b1;
        default: ;
      endcase
      // zero follows every result-producing operation, sign every one except bit test
      case (op)
        `OP_ADD, `OP_SUB, `OP_INC_DEC, `OP_LOGIC, `OP_DEC_ADJ: begin
          flags_d[`FLAG_ZERO] = is_zero(res);
          flags_d[`FLAG_SIGN] = res[7];
        end
        `OP_SHIFT: begin
          flags_d[`FLAG_ZERO] = is_zero(res);
          flags_d[`FLAG_SIGN] = res[7];
        end
        `OP_BIT_TEST: flags_d[`FLAG_ZERO] = is_zero(res);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------
  wire wb_req;
  wire wb_wr;
  wire flags_hit;
  wire sw_flags_we;
  wire direct_we;

  assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands on the edge that samples ack high
  assign wb_wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign flags_hit   = (wb_adr_i == `FLAGS_REG_ADDR);
  assign sw_flags_we = wb_wr & flags_hit & wb_sel_i[0];
  assign direct_we   = load_we | sw_flags_we;
  // both writers at once: value is mixed, software must avoid it
  always @* begin
    collide = direct_we & go & (op != `OP_LOAD) & (op != `OP_NONE);
  end

  // control register write with byte lanes
  always @* begin
    ctrl_d = ctrl_q;
    if (wb_wr && (wb_adr_i == `CTRL_REG_ADDR)) begin
      if (wb_sel_i[0]) ctrl_d[7:0]   = wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_d[15:8]  = wb_dat_i[15:8];
      if (wb_sel_i[2]) ctrl_d[23:16] = wb_dat_i[23:16];
      if (wb_sel_i[3]) ctrl_d[31:24] = wb_dat_i[31:24];
    end
  end

  // ----------------------------------------------------------
  // state update
  // ----------------------------------------------------------
  reg [7:0] flags_n;
  reg [7:0] load_val;

  // merge of the direct writers with the flag logic
  always @* begin
    load_val = load_we ? load_data : wb_dat_i[7:0];
    // collision: or of both writers models the undefined merge
    if (collide) begin
      flags_n = flags_d | load_val;
    end else if (direct_we) begin
      flags_n = load_val;
    end else begin
      flags_n = flags_d;
    end
  end

  // ----------------------------------------------------------
  // flags register and its mirrors
  // ----------------------------------------------------------
  // all flags land together at the end of the execute cycle
  always @(posedge clk) begin
    if (!resetn) begin
      flags_q <= `FLAGS_RESET;
    end else if (clk_en) begin
      flags_q <= flags_n;
    end
  end

  // mirrors load from the next value so they never lag flags_q;
  // the cpu may read either copy in the same cycle
  always @(posedge clk) begin
    if (!resetn) begin
      jump_flags_q  <= 4'h0;
      irq_block_q   <= 1'b0;
      fast_return_q <= 1'b0;
      bank_sel_q    <= 1'b0;
    end else if (clk_en) begin
      jump_flags_q  <= flags_n[7:4];
      irq_block_q   <= flags_n[`FLAG_FAST_IRQ];
      fast_return_q <= flags_n[`FLAG_FAST_IRQ];
      bank_sel_q    <= flags_n[`FLAG_BANK];
    end
  end

  // result is held between operations so software can read it later
  always @(posedge clk) begin
    if (!resetn) begin
      result_q <= 8'h00;
    end else if (clk_en && go) begin
      result_q <= res;
    end
  end

  // ----------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------
  // both are one cycle behind their inputs; the cpu must not use
  // them in the cycle in which it presents the operands
  always @(posedge clk) begin
    if (!resetn) begin
      branch_target_q <= 16'h0000;
      pair_err_q      <= 1'b0;
    end else if (clk_en) begin
      // sign-extended displacement from the following instruction
      branch_target_q <= next_pc
                         + {{8{branch_disp[7]}}, branch_disp};
      pair_err_q      <= pair_addr[0];
    end
  end

  // ----------------------------------------------------------
  // software control and bus response
  // ----------------------------------------------------------
  // go clears itself so that one write runs exactly one operation
  always @(posedge clk) begin
    if (!resetn) begin
      ctrl_q  <= 32'h0000_0000;
      sw_go_q <= 1'b0;
    end else if (clk_en) begin
      ctrl_q  <= {1'b0, ctrl_d[30:0]};
      sw_go_q <= ctrl_d[`CTRL_GO_BIT];
    end
  end

  // ack rises one cycle after the request and drops the next cycle
  always @(posedge clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= wb_req;
    end
  end

  // read data loads with ack so it stands when ack is sampled
  always @(posedge clk) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `CTRL_REG_ADDR:   wb_dat_o <= ctrl_q;
          `RESULT_REG_ADDR: wb_dat_o <= {24'h000000, result_q};
          `FLAGS_REG_ADDR:  wb_dat_o <= {24'h000000, flags_q};
          `STATUS_REG_ADDR: wb_dat_o <= {29'h00000000, pair_err_q,
                                         bank_sel_q, irq_block_q};
          `PAIR_REG_ADDR:   wb_dat_o <= {16'h0000, branch_target_q};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ===== status_flags_map.vh
`ifndef STATUS_FLAGS_MAP_VH
`define STATUS_FLAGS_MAP_VH
// register file address of the flags register, also its wishbone index
`define FLAGS_REG_INDEX   8'hD5
`define FLAGS_REG_ADDR    10'h354
// control register of this block (event-injection port for software)
`define CTRL_REG_ADDR     10'h000
`define RESULT_REG_ADDR   10'h004
`define STATUS_REG_ADDR   10'h008
`define PAIR_REG_ADDR     10'h00C
// flag bit positions
`define FLAG_CARRY        7
`define FLAG_ZERO         6
`define FLAG_SIGN         5
`define FLAG_OVERFLOW     4
`define FLAG_DEC_ADJ      3
`define FLAG_HALF_CARRY   2
`define FLAG_FAST_IRQ     1
`define FLAG_BANK         0
`define FLAGS_RESET       8'h00
// operation codes on the op port
`define OP_NONE           4'h0
`define OP_ADD            4'h1
`define OP_SUB            4'h2
`define OP_LOGIC          4'h3
`define OP_SHIFT          4'h4
`define OP_BIT_TEST       4'h5
`define OP_SET_CARRY      4'h6
`define OP_CLR_CARRY      4'h7
`define OP_CPL_CARRY      4'h8
`define OP_DEC_ADJ        4'h9
`define OP_FAST_IRQ_ENTER 4'hA
`define OP_IRQ_RETURN     4'hB
`define OP_BANK_ZERO      4'hC
`define OP_BANK_ONE       4'hD
`define OP_LOAD           4'hE
`define OP_INC_DEC        4'hF
// fields of the control register
`define CTRL_OP_LSB       0
`define CTRL_A_LSB        8
`define CTRL_B_LSB        16
`define CTRL_CIN_BIT      24
`define CTRL_GO_BIT       31
`endif

// ===== flags_checker_properties.sv
`timescale 1ns/1ps
`include "status_flags_map.vh"
module flags_checker (
  // clock and reset
  input wire        clk,
  input wire        resetn,
  input wire        clk_en,
  // execution inputs
  input wire        exec_valid,
  input wire [3:0]  exec_op,
  input wire [7:0]  exec_a,
  input wire        load_we,
  input wire [15:0] next_pc,
  input wire [7:0]  branch_disp,
  input wire [7:0]  pair_addr,
  // flag outputs
  input wire [7:0]  flags_q,
  input wire [3:0]  jump_flags_q,
  input wire        irq_block_q,
  input wire        fast_return_q,
  input wire        bank_sel_q,
  input wire [15:0] branch_target_q,
  input wire        pair_err_q,
  // bus handshake
  input wire        wb_we_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o
);
  // a lone op; direct writes in the same cycle collide and are not judged
  wire quiet = clk_en && exec_valid && !load_we
    && !(wb_cyc_i && wb_stb_i && wb_we_i);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  jump_copy_a: assert property (
    jump_flags_q == flags_q[7:4])
    else $error("jump flags differ");
  irq_copy_a: assert property (
    irq_block_q == flags_q[1] && fast_return_q == flags_q[1])
    else $error("irq block differs");
  bank_copy_a: assert property (
    bank_sel_q == flags_q[0])
    else $error("bank select differs");
  set_carry_a: assert property (
    quiet && exec_op == `OP_SET_CARRY |=> flags_q[7])
    else $error("carry not set");
  cpl_carry_a: assert property (
    quiet && exec_op == `OP_CPL_CARRY
    |=> flags_q[7] != $past(flags_q[7]))
    else $error("carry not inverted");
  logic_flags_a: assert property (
    quiet && exec_op == `OP_LOGIC |=> flags_q[6:4]
    == {$past(exec_a) == 8'h00, $past(exec_a[7]), 1'b0})
    else $error("logic flags wrong");
  bus_ack_a: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 (!wb_ack_o || !$past(clk_en)))
    else $error("ack not a one cycle pulse");
  branch_sum_a: assert property (
    clk_en |=> branch_target_q == $past(next_pc)
    + {{8{$past(branch_disp[7])}}, $past(branch_disp)})
    else $error("branch target wrong");
  pair_odd_a: assert property (
    clk_en |=> pair_err_q == $past(pair_addr[0]))
    else $error("pair error wrong");
endmodule

// ===== cpu_status_flags_unit_tb_top.sv
`timescale 1ns/1ps
`include "status_flags_map.vh"
module cpu_status_flags_unit_tb_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk = 1'b0, resetn = 1'b0, exec_valid = 1'b0;
  logic [3:0]  exec_op = 4'h0, wb_sel_i = 4'h0;
  logic [7:0]  exec_a = 8'h00, exec_b = 8'h00, load_data = 8'h00;
  logic        exec_cin = 1'b0, exec_shift_out = 1'b0, load_we = 1'b0;
  logic [15:0] next_pc = 16'h0000;
  logic [7:0]  branch_disp = 8'h00, pair_addr = 8'h00;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h00000000, rd;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  wire  [7:0]  flags_q, result_q;
  wire  [3:0]  jump_flags_q;
  wire  [15:0] branch_target_q;
  wire  [31:0] wb_dat_o;
  wire         irq_block_q, fast_return_q, bank_sel_q, pair_err_q, wb_ack_o;
  int          num_errors = 0;
  int          samples_checked = 0;
  logic        clk_en = 1'b1;
  cpu_status_flags_unit dut_u (.clk, .resetn, .clk_en, .exec_valid,
    .exec_op, .exec_a, .exec_b, .exec_cin, .exec_shift_out, .load_we,
    .load_data, .next_pc, .branch_disp, .pair_addr, .flags_q, .jump_flags_q,
    .irq_block_q, .fast_return_q, .bank_sel_q, .result_q, .branch_target_q,
    .pair_err_q, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o);
  always #12.5 clk = ~clk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one op held for one edge; flags settle at that edge
  task automatic step(input [3:0] op, input [7:0] a, b, input [1:0] cs);
    @(posedge clk);
    exec_valid <= 1'b1;
    {exec_op, exec_a, exec_b, exec_cin, exec_shift_out} <= {op, a, b, cs};
    @(posedge clk);
    exec_valid <= 1'b0;
    #1;
  endtask
  // classic cycle, held until ack is sampled; bounded wait
  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    wb_sel_i <= 4'hF;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_arith;
    step(`OP_ADD, 8'hFF, 8'h01, 2'b00);
    chk("fl", flags_q, 8'hC4);
    chk("jmp", jump_flags_q, 4'hC);
    step(`OP_ADD, 8'h7F, 8'h01, 2'b00);
    chk("fl", flags_q, 8'h34);
    step(`OP_SUB, 8'h00, 8'h01, 2'b00);
    chk("fl", flags_q, 8'hAC);
    chk("res", result_q, 8'hFF);
    step(`OP_SUB, 8'h80, 8'h01, 2'b00);
    chk("fl", flags_q, 8'h1C);
    step(`OP_ADD, 8'h0F, 8'h00, 2'b10);
    chk("fl", flags_q, 8'h04);
  endtask
  task automatic t_logic_shift;
    step(`OP_LOGIC, 8'h00, 8'h00, 2'b00);
    chk("lz", flags_q & 8'h70, 8'h40);
    step(`OP_LOGIC, 8'h80, 8'h00, 2'b00);
    chk("ls", flags_q & 8'h70, 8'h20);
    step(`OP_SHIFT, 8'h00, 8'h00, 2'b01);
    chk("sh", flags_q & 8'hE0, 8'hC0);
    step(`OP_SHIFT, 8'h81, 8'h00, 2'b00);
    chk("sh", flags_q & 8'hE0, 8'h20);
    step(`OP_BIT_TEST, 8'hF0, 8'h0F, 2'b00);
    chk("bt", flags_q & 8'h40, 8'h40);
    step(`OP_BIT_TEST, 8'hF0, 8'h10, 2'b00);
    chk("bt", flags_q & 8'h40, 8'h00);
    step(`OP_INC_DEC, 8'h7F, 8'h01, 2'b00);
    chk("id", flags_q & 8'hF0, 8'h30);
  endtask
  task automatic t_carry_mode;
    step(`OP_SET_CARRY, 8'h00, 8'h00, 2'b00);
    chk("c", flags_q[7], 1'b1);
    step(`OP_CLR_CARRY, 8'h00, 8'h00, 2'b00);
    chk("c", flags_q[7], 1'b0);
    step(`OP_CPL_CARRY, 8'h00, 8'h00, 2'b00);
    chk("c", flags_q[7], 1'b1);
    step(`OP_FAST_IRQ_ENTER, 8'h00, 8'h00, 2'b00);
    chk("fi", irq_block_q, 1'b1);
    step(`OP_BANK_ONE, 8'h00, 8'h00, 2'b00);
    chk("bk", flags_q[1:0], 2'b11);
    step(`OP_IRQ_RETURN, 8'h00, 8'h00, 2'b00);
    chk("fr", fast_return_q, 1'b0);
    step(`OP_BANK_ZERO, 8'h00, 8'h00, 2'b00);
    chk("bk", bank_sel_q, 1'b0);
  endtask
  task automatic t_adjust;
    step(`OP_ADD, 8'h09, 8'h08, 2'b00);
    step(`OP_DEC_ADJ, 8'h11, 8'h00, 2'b00);
    chk("da", result_q, 8'h17);
    step(`OP_SUB, 8'h10, 8'h01, 2'b00);
    step(`OP_DEC_ADJ, 8'h0F, 8'h00, 2'b00);
    chk("da", result_q, 8'h09);
  endtask
  task automatic t_direct;
    @(posedge clk);
    load_we <= 1'b1;
    load_data <= 8'hA5;
    next_pc <= 16'h1000;
    branch_disp <= 8'h80;
    pair_addr <= 8'h03;
    @(posedge clk);
    load_we <= 1'b0;
    #1;
    chk("ld", flags_q, 8'hA5);
    @(posedge clk);
    #1;
    chk("br", branch_target_q, 16'h0F80);
    chk("pr", pair_err_q, 1'b1);
    wb(1'b1, `FLAGS_REG_ADDR, 32'h0000003C, rd);
    wb(1'b0, `FLAGS_REG_ADDR, 32'h00000000, rd);
    chk("wb", rd, 32'h3C);
    wb(1'b0, 10'h100, 32'h00000000, rd);
    chk("um", rd, 32'h0);
  endtask
  // software go runs add 03 + 02, then status and target read back
  task automatic t_soft;
    wb(1'b1, `CTRL_REG_ADDR, 32'h8002_0301, rd);
    wb(1'b0, `RESULT_REG_ADDR, 32'h0, rd);
    chk("sw", rd, 32'h05);
    chk("swf", flags_q, 8'h00);
    wb(1'b0, `STATUS_REG_ADDR, 32'h0, rd);
    chk("st", rd, 32'h4);
    wb(1'b0, `PAIR_REG_ADDR, 32'h0, rd);
    chk("pc", rd, 32'h0F80);
  endtask
  // with the enable low a set-carry op must leave the carry flag alone
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    step(`OP_SET_CARRY, 8'h00, 8'h00, 2'b00);
    chk("frz", flags_q[7], 1'b0);
    @(posedge clk);
    clk_en <= 1'b1;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("rst", flags_q, `FLAGS_RESET);
    t_arith();
    t_logic_shift();
    t_carry_mode();
    t_adjust();
    t_direct();
    t_soft();
    t_freeze();
    give_verdict();
  end
endmodule
bind cpu_status_flags_unit flags_checker chk_u (.clk, .resetn, .clk_en,
  .exec_valid, .exec_op, .exec_a, .load_we, .next_pc, .branch_disp,
  .pair_addr, .flags_q, .jump_flags_q, .irq_block_q, .fast_return_q,
  .bank_sel_q, .branch_target_q, .pair_err_q, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o);
